// ---- include/uart_line_control_defines.vh ----
`ifndef UART_LINE_CONTROL_DEFINES_VH
`define UART_LINE_CONTROL_DEFINES_VH

// Register byte addresses
`define ADDR_DATA 32'hffff0700
`define ADDR_IRQ_DIVHI 32'hffff0704
`define ADDR_LINE_CONTROL 32'hffff070c
`define ADDR_AUX_LINE_CONTROL 32'hffff0710
`define ADDR_LINE_STATUS 32'hffff0714

// Reset values
`define RST_LINE_CONTROL 8'h00
`define RST_AUX_LINE_CONTROL 8'h00
`define RST_LINE_STATUS 8'h60

// line_control fields
`define LC_DIVISOR_ACCESS 7
`define LC_BREAK_FORCE 6
`define LC_STICK_PARITY 5
`define LC_PARITY_EVEN_SELECT 4
`define LC_PARITY_ENABLE 3
`define LC_STOP_SELECT 2
`define LC_WORD_LENGTH_HI 1
`define LC_WORD_LENGTH_LO 0

// aux_line_control fields
`define AUX_RX_SOURCE_HI 7
`define AUX_RX_SOURCE_LO 6
`define AUX_LOOPBACK 4
`define RX_SOURCE_LIN 2'h0
`define RX_SOURCE_GPIO5 2'h2

// line_status fields
`define LS_TRANSMITTER_EMPTY 6
`define LS_TX_HOLDING_EMPTY 5
`define LS_BREAK_FLAG 4
`define LS_FRAMING_ERROR 3
`define LS_PARITY_ERROR 2
`define LS_OVERRUN 1
`define LS_RX_DATA_READY 0

// Oversample ticks per bit time
`define TICKS_PER_BIT 6'h10
`define TICKS_HALF_BIT 6'h08
`define TICKS_STOP_ONE_HALF 6'h18
`define TICKS_STOP_TWO 6'h20

`endif

// ---- src/uart_line_control.v ----
// Functional notes
// - divisor_access set maps shared slots to divisor bytes, else data and irq enable.
// - break_force holds the transmit pin at 0 while set.
// - stick parity with parity enable sends parity equal to even-select bit.
// - even-select set gives even parity, cleared odd, for send and check.
// - parity enable adds a parity bit on transmit and checks it on receive.
// - word length 5..8 bits; stop select gives 1.5 (5-bit) or 2 stop bits.
// - receiver validates only the first stop bit.
// - receive source 00 is LIN input, 10 is general-purpose pin 5.
// - loopback bit enables loopback and holds the transmit pin high unless break_force is set.
// - line status is read-only, 8 bits, resets to 0x60.
// - transmit, receive and divisor low byte share one address.
// - both transmit-empty flags set when empty, clear on transmit data write.
// - data-ready sets when receive data fills, clears on receive data read.
// - status bits 4..1 flag break, framing, parity and overrun errors.
`include "uart_line_control_defines.vh"
module uart_line_control
(
   input wire ref_clk,
   input wire rst_n,
   input wire [31:0] busAddr,
   input wire busWrite,
   input wire busRead,
   input wire [7:0] busWdata,
   output reg [7:0] busRdata,
   input wire linRxIn,
   input wire gpio5RxIn,
   output wire txOut
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_START = 5'h02;
   localparam [4:0] S_DATA = 5'h04;
   localparam [4:0] S_PARITY = 5'h08;
   localparam [4:0] S_STOP = 5'h10;

   reg [7:0] lineControl, auxLineControl, irqEnable, divisorLow, divisorHigh;
   reg [7:0] txHolding, txShift, rxData, rxShift;
   reg txHoldingEmpty, dataReady, overrun, parityError, framingError, breakFlag;
   reg [15:0] divCount;
   reg [1:0] linSync, gpioSync;
   reg [4:0] txState, rxState;
   reg [5:0] txTicks, rxTicks;
   reg [2:0] txBit, rxBit;
   reg txLine, rxParity, rxPrev;

   wire divisor_access = lineControl[`LC_DIVISOR_ACCESS];
   wire loopback = auxLineControl[`AUX_LOOPBACK];
   wire [1:0] rxSource = auxLineControl[`AUX_RX_SOURCE_HI:`AUX_RX_SOURCE_LO];
   wire [2:0] lastBit = {1'b1, lineControl[`LC_WORD_LENGTH_HI:`LC_WORD_LENGTH_LO]};
   wire [7:0] wordMask = 8'hff >> (3'h3 - {1'b0, lineControl[`LC_WORD_LENGTH_HI:`LC_WORD_LENGTH_LO]});
   wire parityOn = lineControl[`LC_PARITY_ENABLE];
   wire evenSel = lineControl[`LC_PARITY_EVEN_SELECT];
   wire stick = lineControl[`LC_STICK_PARITY];

   wire accData = (busAddr == `ADDR_DATA) && !divisor_access;
   wire accDivLow = (busAddr == `ADDR_DATA) && divisor_access;
   wire accDivHigh = (busAddr == `ADDR_IRQ_DIVHI) && divisor_access;
   wire accIrq = (busAddr == `ADDR_IRQ_DIVHI) && !divisor_access;
   wire txWrite = busWrite && accData;
   wire rxRead = busRead && accData;
   wire statusRead = busRead && (busAddr == `ADDR_LINE_STATUS);

   // Divisor 0 behaves as 1 so the tick never stalls
   wire [15:0] divisor = {divisorHigh, divisorLow};
   wire tick = (divCount == 16'h0000);
   wire transmitterEmpty = txHoldingEmpty && txState[0];

   // Stick parity sends the even-select bit as a constant
   function parityBit;
      input [7:0] data;
      begin
         parityBit = stick ? evenSel : (evenSel ? ^data : ~^data);
      end
   endfunction

   wire [7:0] lineStatus = {1'b0, transmitterEmpty, txHoldingEmpty, breakFlag, framingError,
      parityError, overrun, dataReady};
   wire rxExternal = (rxSource == `RX_SOURCE_GPIO5) ? gpioSync[1] : linSync[1];
   wire rxLine = loopback ? txLine : rxExternal;
   assign txOut = lineControl[`LC_BREAK_FORCE] ? 1'b0 : (loopback ? 1'b1 : txLine);

   wire [5:0] stopTicks = !lineControl[`LC_STOP_SELECT] ? `TICKS_PER_BIT :
      (lastBit == 3'h4 ? `TICKS_STOP_ONE_HALF : `TICKS_STOP_TWO);

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         lineControl <= `RST_LINE_CONTROL;
         auxLineControl <= `RST_AUX_LINE_CONTROL;
         irqEnable <= 8'h00;
         divisorLow <= 8'h00;
         divisorHigh <= 8'h00;
         busRdata <= 8'h00;
         linSync <= 2'h3;
         gpioSync <= 2'h3;
         divCount <= 16'h0000;
      end
      else
      begin
         linSync <= {linSync[0], linRxIn};
         gpioSync <= {gpioSync[0], gpio5RxIn};
         divCount <= tick ? ((divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001) : divCount - 16'h0001;
         if (busWrite && busAddr == `ADDR_LINE_CONTROL)
            lineControl <= busWdata;
         if (busWrite && busAddr == `ADDR_AUX_LINE_CONTROL)
            auxLineControl <= busWdata;
         if (busWrite && accIrq)
            irqEnable <= busWdata;
         if (busWrite && accDivLow)
            divisorLow <= busWdata;
         if (busWrite && accDivHigh)
            divisorHigh <= busWdata;
         if (busRead)
         begin
            if (accData)
               busRdata <= rxData;
            else if (accDivLow)
               busRdata <= divisorLow;
            else if (accDivHigh)
               busRdata <= divisorHigh;
            else if (accIrq)
               busRdata <= irqEnable;
            else if (busAddr == `ADDR_LINE_CONTROL)
               busRdata <= lineControl;
            else if (busAddr == `ADDR_AUX_LINE_CONTROL)
               busRdata <= auxLineControl;
            else if (busAddr == `ADDR_LINE_STATUS)
               busRdata <= lineStatus;
            else
               busRdata <= 8'h00;
         end
      end
   end

   // Transmitter: holding register feeds the shifter when it goes idle
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         txHolding <= 8'h00;
         txShift <= 8'h00;
         txHoldingEmpty <= 1'b1;
         txState <= S_IDLE;
         txTicks <= 6'h00;
         txBit <= 3'h0;
         txLine <= 1'b1;
      end
      else
      begin
         if (txWrite)
         begin
            txHolding <= busWdata;
            txHoldingEmpty <= 1'b0;
         end
         else if (txState[0] && !txHoldingEmpty)
            txHoldingEmpty <= 1'b1;
         if (txState[0] && tick)
            txTicks <= 6'h00;
         else if (tick)
            txTicks <= txTicks + 6'h01;
         case (txState)
            S_IDLE:
            begin
               txLine <= 1'b1;
               if (!txHoldingEmpty)
               begin
                  txShift <= txHolding & wordMask;
                  txState <= S_START;
                  txTicks <= 6'h00;
                  txLine <= 1'b0;
               end
            end
            S_START:
               if (tick && txTicks == `TICKS_PER_BIT - 6'h01)
               begin
                  txTicks <= 6'h00;
                  txBit <= 3'h0;
                  txLine <= txShift[0];
                  txState <= S_DATA;
               end
            S_DATA:
               if (tick && txTicks == `TICKS_PER_BIT - 6'h01)
               begin
                  txTicks <= 6'h00;
                  txBit <= txBit + 3'h1;
                  if (txBit == lastBit)
                  begin
                     txLine <= parityOn ? parityBit(txShift) : 1'b1;
                     txState <= parityOn ? S_PARITY : S_STOP;
                  end
                  else
                     txLine <= txShift[txBit + 3'h1];
               end
            S_PARITY:
               if (tick && txTicks == `TICKS_PER_BIT - 6'h01)
               begin
                  txTicks <= 6'h00;
                  txLine <= 1'b1;
                  txState <= S_STOP;
               end
            S_STOP:
               if (tick && txTicks == stopTicks - 6'h01)
                  txState <= S_IDLE;
            default:
               txState <= S_IDLE;
         endcase
      end
   end

   // Receiver: 16 ticks per bit, sampling mid-bit
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rxState <= S_IDLE;
         rxTicks <= 6'h00;
         rxBit <= 3'h0;
         rxShift <= 8'h00;
         rxParity <= 1'b0;
         rxPrev <= 1'b1;
         rxData <= 8'h00;
         dataReady <= 1'b0;
         overrun <= 1'b0;
         parityError <= 1'b0;
         framingError <= 1'b0;
         breakFlag <= 1'b0;
      end
      else
      begin
         rxPrev <= rxLine;
         // Status reads clear errors; a new event in that cycle still lands
         if (statusRead)
         begin
            overrun <= 1'b0;
            parityError <= 1'b0;
            framingError <= 1'b0;
            breakFlag <= 1'b0;
         end
         if (rxRead)
            dataReady <= 1'b0;
         if (tick)
            rxTicks <= rxTicks + 6'h01;
         case (rxState)
            S_IDLE:
               if (rxPrev && !rxLine)
               begin
                  rxTicks <= 6'h00;
                  rxState <= S_START;
               end
            S_START:
               if (tick && rxTicks == `TICKS_HALF_BIT - 6'h01)
               begin
                  rxTicks <= 6'h00;
                  rxBit <= 3'h0;
                  rxShift <= 8'h00;
                  rxState <= rxLine ? S_IDLE : S_DATA;
               end
            S_DATA:
               if (tick && rxTicks == `TICKS_PER_BIT - 6'h01)
               begin
                  rxTicks <= 6'h00;
                  rxShift[rxBit] <= rxLine;
                  rxBit <= rxBit + 3'h1;
                  if (rxBit == lastBit)
                     rxState <= parityOn ? S_PARITY : S_STOP;
               end
            S_PARITY:
               if (tick && rxTicks == `TICKS_PER_BIT - 6'h01)
               begin
                  rxTicks <= 6'h00;
                  rxParity <= rxLine;
                  rxState <= S_STOP;
               end
            S_STOP:
               if (tick && rxTicks == `TICKS_PER_BIT - 6'h01)
               begin
                  // Only this first stop bit is judged
                  rxState <= S_IDLE;
                  rxData <= rxShift;
                  dataReady <= 1'b1;
                  if (dataReady && !rxRead)
                     overrun <= 1'b1;
                  if (!rxLine)
                     framingError <= 1'b1;
                  if (parityOn && rxParity != parityBit(rxShift))
                     parityError <= 1'b1;
                  if (!rxLine && rxShift == 8'h00 && (!parityOn || !rxParity))
                     breakFlag <= 1'b1;
               end
            default:
               rxState <= S_IDLE;
         endcase
      end
   end
endmodule

// ---- tb/uart_line_control_properties.sv ----
`include "uart_line_control_defines.vh"
module uart_line_control_properties
(
   input wire ref_clk,
   input wire rst_n,
   input wire [31:0] busAddr,
   input wire busWrite,
   input wire busRead,
   input wire [7:0] busWdata,
   input wire [7:0] busRdata,
   input wire linRxIn,
   input wire gpio5RxIn,
   input wire txOut
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [7:0] lc;
   reg [7:0] aux;
   reg [7:0] divLow;
   reg fresh;
   // Shadow copies of the control registers, built from bus writes only
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         lc <= 8'h00;
         aux <= 8'h00;
         divLow <= 8'h00;
         fresh <= 1'b1;
      end
      else if (busWrite)
      begin
         fresh <= 1'b0;
         if (busAddr == `ADDR_LINE_CONTROL)
            lc <= busWdata;
         if (busAddr == `ADDR_AUX_LINE_CONTROL)
            aux <= busWdata;
         if (busAddr == `ADDR_DATA && lc[7])
            divLow <= busWdata;
      end
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_tx_wr;
      busWrite && busAddr == `ADDR_DATA && !lc[7];
   endsequence
   sequence s_ls_rd;
      busRead && busAddr == `ADDR_LINE_STATUS;
   endsequence
   property p_break;
      lc[6] |-> !txOut;
   endproperty
   property p_loop;
      aux[4] && !lc[6] |-> txOut;
   endproperty
   property p_idle;
      fresh && !lc[6] |-> txOut;
   endproperty
   property p_reset_status;
      fresh ##0 s_ls_rd |=> busRdata == 8'h60;
   endproperty
   property p_lc_rd;
      busRead && busAddr == `ADDR_LINE_CONTROL |=> busRdata == lc;
   endproperty
   property p_aux_rd;
      busRead && busAddr == `ADDR_AUX_LINE_CONTROL |=> (busRdata & 8'hd0) == (aux & 8'hd0);
   endproperty
   property p_div_rd;
      busRead && busAddr == `ADDR_DATA && lc[7] |=> busRdata == divLow;
   endproperty
   property p_transmitter_empty;
      s_tx_wr ##2 s_ls_rd |=> !busRdata[6];
   endproperty
   a_break: assert property (p_break) else $error("tx not low in break");
   a_loop: assert property (p_loop) else $error("tx not high in loopback");
   a_idle: assert property (p_idle) else $error("tx not idle high");
   a_reset_status: assert property (p_reset_status) else $error("status reset value wrong");
   a_lc_rd: assert property (p_lc_rd) else $error("line control readback wrong");
   a_aux_rd: assert property (p_aux_rd) else $error("aux control readback wrong");
   a_div_rd: assert property (p_div_rd) else $error("divisor low readback wrong");
   a_transmitter_empty: assert property (p_transmitter_empty) else $error("transmitter empty after write");
endmodule
bind uart_line_control uart_line_control_properties i_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
   .linRxIn(linRxIn), .gpio5RxIn(gpio5RxIn), .txOut(txOut));

// ---- tb/serial_peer.sv ----
module serial_peer
#(parameter int BT = 32)
(
   input wire ref_clk,
   output logic linRxIn,
   output logic gpio5RxIn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      linRxIn = 1'b1;
      gpio5RxIn = 1'b1;
   end
   // Parity and stop values come from the caller so faults can be injected
   task automatic send(input bit g, input logic [7:0] d, input int n, input bit parity_enable, input logic p, input logic s);
      logic v;
      // Stop bit is held a full bit time, then the line goes back to idle high
      for (int k = 0; k <= n + 3; k++)
      begin
         v = k == 0 ? 1'b0 : k <= n ? d[k-1] : k == n + 1 ? p : k == n + 2 ? s : 1'b1;
         if (k == n + 1 && !parity_enable)
            continue;
         @(negedge ref_clk);
         if (g)
            gpio5RxIn = v;
         else
            linRxIn = v;
         if (k <= n + 2)
            repeat (BT - 1) @(negedge ref_clk);
      end
   endtask
endmodule

// ---- tb/test_uart_line_control.sv ----
`include "uart_line_control_defines.vh"
module test_uart_line_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BT = 32;
   localparam bit [31:0] DAT = `ADDR_DATA, IRQ = `ADDR_IRQ_DIVHI, LC = `ADDR_LINE_CONTROL;
   localparam bit [31:0] AUX = `ADDR_AUX_LINE_CONTROL, LS = `ADDR_LINE_STATUS;
   logic ref_clk = 0, rst_n = 0, busWrite = 0, busRead = 0;
   logic [31:0] busAddr = 0;
   logic [7:0] busWdata = 0;
   wire [7:0] busRdata;
   wire linRxIn, gpio5RxIn, txOut;
   int errors = 0, checks_done = 0;
   always #2 ref_clk = ~ref_clk;
   uart_line_control i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .busAddr(busAddr), .busWrite(busWrite),
      .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata), .linRxIn(linRxIn),
      .gpio5RxIn(gpio5RxIn), .txOut(txOut));
   serial_peer #(.BT(BT)) i_peer (.ref_clk(ref_clk), .linRxIn(linRxIn), .gpio5RxIn(gpio5RxIn));
   task stop_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // Extra idle cycle keeps a strobe from being lowered and raised in one step
   task wr(input logic [31:0] a, input logic [7:0] d);
      busAddr = a;
      busWdata = d;
      busWrite = 1'b1;
      @(negedge ref_clk);
      busWrite = 1'b0;
      @(negedge ref_clk);
   endtask
   task rd(input logic [31:0] a, output logic [7:0] v);
      busAddr = a;
      busRead = 1'b1;
      @(negedge ref_clk);
      busRead = 1'b0;
      v = busRdata;
      @(negedge ref_clk);
   endtask
   task rck(input logic [31:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk($sformatf("reg %h", a), v, e);
   endtask
   task wait_tx;
      logic [7:0] v;
      for (int t = 0; t < 400; t++)
      begin
         rd(LS, v);
         if (v[6] === 1'b1)
            return;
      end
      errors++;
      stop_test;
   endtask
   function automatic logic frame_bit(input logic [7:0] c, input logic [7:0] d, input int k);
      int n;
      n = 5 + c[1:0];
      if (k == 0)
         return 1'b0;
      if (k <= n)
         return d[k-1];
      if (c[3] && k == n + 1)
         return c[5] ? c[4] : ~^(d & ~(8'hff << n)) ^ c[4];
      return 1'b1;
   endfunction
   task t_regs;
      rck(LS, 8'h60);
      rck(LC, 8'h00);
      rck(AUX, 8'h00);
      rck(32'hffff0718, 8'h00);
      wr(LS, 8'h00);
      rck(LS, 8'h60);
   endtask
   task t_div;
      wr(LC, 8'h80);
      wr(DAT, 8'h02);
      wr(IRQ, 8'h00);
      rck(DAT, 8'h02);
      wr(LC, 8'h00);
      wr(IRQ, 8'h05);
      rck(IRQ, 8'h05);
      wr(LC, 8'h80);
      rck(IRQ, 8'h00);
   endtask
   task t_tx;
      logic [7:0] cfg [7] = '{8'h03, 8'h00, 8'h1b, 8'h0a, 8'h39, 8'h2d, 8'h04};
      logic [7:0] v;
      logic e;
      for (int i = 0; i < 7; i++)
      begin
         wr(LC, cfg[i]);
         wr(DAT, 8'hb6);
         rd(LS, v);
         chk("transmitter_empty", {7'h0, v[6]}, 8'h00);
         repeat (BT / 2 - 6) @(negedge ref_clk);
         for (int k = 0; k <= 6 + cfg[i][1:0] + cfg[i][3]; k++)
         begin
            e = frame_bit(cfg[i], 8'hb6, k);
            chk($sformatf("tx %0d bit %0d", i, k), {7'h0, txOut}, {7'h0, e});
            repeat (BT) @(negedge ref_clk);
         end
         // About 45 cycles into the stop: one stop bit is over, 1.5 or 2 are not
         rd(LS, v);
         chk($sformatf("stop len %0d", i), {7'h0, v[6]}, {7'h0, ~cfg[i][2]});
         wait_tx;
      end
   endtask
   task t_rx;
      wr(LC, 8'h1b);
      i_peer.send(0, 8'ha5, 8, 1, 1'b1, 1'b1);
      rck(LS, 8'h65);
      rck(DAT, 8'ha5);
      wr(LC, 8'h1f);
      i_peer.send(0, 8'ha5, 8, 1, 1'b0, 1'b0);
      rck(LS, 8'h69);
      rck(DAT, 8'ha5);
      wr(AUX, 8'h80);
      wr(LC, 8'h00);
      i_peer.send(0, 8'h13, 5, 0, 1'b0, 1'b1);
      rck(LS, 8'h60);
      i_peer.send(1, 8'h13, 5, 0, 1'b0, 1'b1);
      rck(LS, 8'h61);
      rck(DAT, 8'h13);
      rck(LS, 8'h60);
      i_peer.send(1, 8'h00, 5, 0, 1'b0, 1'b0);
      rck(LS, 8'h79);
      i_peer.send(1, 8'h0a, 5, 0, 1'b0, 1'b1);
      rck(LS, 8'h63);
      rck(DAT, 8'h0a);
      rck(LS, 8'h60);
   endtask
   task t_misc;
      wr(LC, 8'h40);
      chk("break", {7'h0, txOut}, 8'h00);
      wr(LC, 8'h03);
      wr(AUX, 8'h10);
      wr(DAT, 8'h3c);
      repeat (BT) @(negedge ref_clk);
      chk("loop tx", {7'h0, txOut}, 8'h01);
      wait_tx;
      rck(DAT, 8'h3c);
   endtask
   initial
   begin
      repeat (16) @(negedge ref_clk);
      rst_n = 1'b1;
      t_regs;
      t_div;
      t_tx;
      t_rx;
      t_misc;
      stop_test;
   end
endmodule
